// ===== verilog/rrts_pkg.sv
package rrts_pkg;
    // Strap sample delay after reset release
    localparam int STRAP_DELAY_NS = 1500;
    localparam int CLK_PERIOD_NS = 10;
    // Roughly 1.5 us: a nominal figure, so round up to a whole cycle count
    localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_CNT_W = 12;
    localparam int STRAP_PINS = 8;
    localparam logic [7:0] STRAP_RESET_VAL = 8'h00;
    localparam logic [7:0] STRAP_OUT_RESET_VAL = 8'h00;
    typedef enum logic [1:0] {
        RRTS_ST_RESET = 2'b00,
        RRTS_ST_WAIT = 2'b01,
        RRTS_ST_CONFIG = 2'b10,
        RRTS_ST_RUN = 2'b11
    } rrts_state_t;
endpackage

// ===== verilog/rrts_delay.sv
`timescale 1ns/1ps
module rrts_delay
    import rrts_pkg::*;
#(
    parameter int COUNT = STRAP_DELAY_CYC
) (
    input wire logic ref_clk_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic start_in, // Level: count while high
    output logic done_out // Pulse when count reached
);
    logic [STRAP_CNT_W-1:0] count;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !start_in) begin
            count <= '0;
        end else if (count != STRAP_CNT_W'(COUNT)) begin
            count <= count + STRAP_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !start_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= (count == STRAP_CNT_W'(COUNT - 1));
        end
    end
endmodule

// ===== verilog/rrts_top.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Rising edge on power-on reset input starts the self-configuration sequence.
// R2: External source holds reset low until supplies and clocks are stable.
// R3: All outputs stay inactive while the power-on reset input is low; the code holds test_strap_pin_pd_out high throughout.
// R4: Strap pins float, weak pulldown only, while reset input is low.
// R5: Straps sampled about 1.5 us after reset release, then driven as outputs.
// R6: Any strap high may select test mode; all low means normal operation.
// R7: Captured strap selection holds until the next reset assertion.
module rrts_top
    import rrts_pkg::*;
#(
    parameter int PINS = STRAP_PINS
) (
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic rst_n_in, // Synchronous system reset, active low
    input wire logic power_on_reset_n_in, // Power-on reset pin, active low
    input wire logic [PINS-1:0] test_strap_pin_in, // Strap pin input levels
    output logic [PINS-1:0] test_strap_pin_out, // Strap pin drive values
    output logic [PINS-1:0] test_strap_pin_oe_n_out, // Low while driving
    output logic [PINS-1:0] test_strap_pin_pd_out, // Weak pulldown enable
    input wire logic [PINS-1:0] test_data_in, // Test output data once driven
    output logic [PINS-1:0] test_mode_sel_out, // Captured strap selection
    output logic test_mode_out, // High when any strap sampled high
    output logic normal_mode_out, // High for normal operation
    output logic config_start_out, // One-cycle pulse starting self-config
    output logic config_active_out // High while self-configuration runs
);
    ////////////////////////////////////////////////////////////////////////
    rrts_state_t state, next_state;
    logic por_prev;
    logic delay_done;
    logic por_rise;

    // Pins are driven once the straps have been captured
    function automatic logic pins_driven(input rrts_state_t st);
        return (st == RRTS_ST_CONFIG) || (st == RRTS_ST_RUN);
    endfunction

    // Edge detect; input treated as synchronous to the clock
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            por_prev <= 1'b0;
        end else begin
            por_prev <= power_on_reset_n_in;
        end
    end
    assign por_rise = power_on_reset_n_in && !por_prev; // [R1]

    rrts_delay #(
        .COUNT(STRAP_DELAY_CYC)
    ) i_rrts_delay (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(state == RRTS_ST_WAIT),
        .done_out(delay_done)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            RRTS_ST_RESET: begin
                if (por_rise) begin
                    next_state = RRTS_ST_WAIT; // [R1]
                end
            end
            RRTS_ST_WAIT: begin
                if (delay_done) begin
                    next_state = RRTS_ST_CONFIG; // [R5]
                end
            end
            RRTS_ST_CONFIG: begin
                next_state = RRTS_ST_RUN;
            end
            RRTS_ST_RUN: begin
                next_state = RRTS_ST_RUN;
            end
            default: begin
                next_state = RRTS_ST_RESET;
            end
        endcase
        // Reset assertion overrides everything, even mid-wait
        if (!power_on_reset_n_in) begin
            next_state = RRTS_ST_RESET; // [R3]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state <= RRTS_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture once at the end of the wait; cleared only by reset
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !power_on_reset_n_in) begin
            test_mode_sel_out <= STRAP_RESET_VAL[PINS-1:0]; // [R7]
        end else if (state == RRTS_ST_WAIT && delay_done) begin
            test_mode_sel_out <= test_strap_pin_in; // [R5]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !power_on_reset_n_in) begin
            test_strap_pin_out <= STRAP_OUT_RESET_VAL[PINS-1:0]; // [R3]
        end else if (state == RRTS_ST_RUN) begin
            test_strap_pin_out <= test_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !power_on_reset_n_in) begin
            config_start_out <= 1'b0;
            config_active_out <= 1'b0;
        end else begin
            config_start_out <= (state == RRTS_ST_WAIT) && delay_done; // [R1]
            config_active_out <= (next_state == RRTS_ST_CONFIG);
        end
    end

    // Drive only after sampling; pins float during reset and the wait
    assign test_strap_pin_oe_n_out = pins_driven(state)
        ? {PINS{1'b0}} : {PINS{1'b1}}; // [R4] [R5]
    assign test_strap_pin_pd_out = {PINS{1'b1}}; // [R4]
    assign test_mode_out = (state == RRTS_ST_RUN) && (|test_mode_sel_out); // [R6]
    assign normal_mode_out = (state == RRTS_ST_RUN) && !(|test_mode_sel_out); // [R6]

    ////////////////////////////////////////////////////////////////////////
    // Checker helper: edges since the rise was taken, saturating past the sample point.
    // Kept apart from the delay counter so the timing check does not lean on it.
    localparam logic [STRAP_CNT_W-1:0] CHK_SAMPLE = STRAP_CNT_W'(STRAP_DELAY_CYC + 2);
    localparam logic [STRAP_CNT_W-1:0] CHK_SAT = STRAP_CNT_W'(STRAP_DELAY_CYC + 3);
    logic [STRAP_CNT_W-1:0] chk_since_rise;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !power_on_reset_n_in) begin
            chk_since_rise <= '0;
        end else if (state == RRTS_ST_RESET && por_rise) begin
            chk_since_rise <= STRAP_CNT_W'(1);
        end else if (chk_since_rise != '0 && chk_since_rise != CHK_SAT) begin
            chk_since_rise <= chk_since_rise + STRAP_CNT_W'(1);
        end
    end

    a_float_in_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R4]
        !power_on_reset_n_in |=> &test_strap_pin_oe_n_out)
        else $error("strap pins driven during reset");

    a_outputs_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R3]
        !power_on_reset_n_in |=> !config_start_out && !test_mode_out
            && !normal_mode_out && !config_active_out)
        else $error("output active during reset");

    a_sample_time: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        config_start_out == (chk_since_rise == CHK_SAMPLE))
        else $error("strap sample not at 1.5 us");

    a_no_early_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
        por_rise |=> !config_start_out [*8])
        else $error("config started too early");

    a_sel_stable: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R7]
        state == RRTS_ST_RUN && $past(state) == RRTS_ST_RUN && power_on_reset_n_in
        |-> $stable(test_mode_sel_out))
        else $error("strap selection changed");

    a_mode_decode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R6]
        state == RRTS_ST_RUN |-> (test_mode_out == (test_mode_sel_out != '0))
            && (normal_mode_out != test_mode_out))
        else $error("mode decode wrong");

    a_drive_after: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        config_start_out && power_on_reset_n_in |-> ~|test_strap_pin_oe_n_out)
        else $error("strap pins not driven after sample");

    a_pulldown_on: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R4]
        !power_on_reset_n_in |-> &test_strap_pin_pd_out)
        else $error("pulldown off in reset");

    a_start_one_cycle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
        config_start_out |=> !config_start_out)
        else $error("config start longer than one cycle");

    a_active_with_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
        config_active_out == config_start_out)
        else $error("config active not with config start");

    a_rise_leaves_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
        state == RRTS_ST_RESET && por_rise |=> state == RRTS_ST_WAIT)
        else $error("reset rise did not start the wait");

    a_start_in_config: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
        config_start_out |-> state == RRTS_ST_CONFIG)
        else $error("config start outside config state");

    a_sel_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        config_start_out |-> test_mode_sel_out == $past(test_strap_pin_in))
        else $error("strap selection not taken from pins");

    a_sel_cleared: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R7]
        !power_on_reset_n_in |=> test_mode_sel_out == STRAP_RESET_VAL[PINS-1:0])
        else $error("strap selection kept through reset");

    a_data_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R3]
        !power_on_reset_n_in |=> test_strap_pin_out == STRAP_OUT_RESET_VAL[PINS-1:0])
        else $error("pin data active during reset");

    a_float_in_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        state == RRTS_ST_WAIT |-> &test_strap_pin_oe_n_out)
        else $error("strap pins driven before sample");

    a_drive_in_run: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        state == RRTS_ST_RUN |-> ~|test_strap_pin_oe_n_out)
        else $error("strap pins not driven in run");

    a_data_passed: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R5]
        $past(state) == RRTS_ST_RUN && $past(power_on_reset_n_in) && $past(rst_n_in)
        |-> test_strap_pin_out == $past(test_data_in))
        else $error("pin data not passed in run");

    a_modes_exclusive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R6]
        !(test_mode_out && normal_mode_out))
        else $error("test and normal mode both high");

    a_mode_only_run: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R3]
        state != RRTS_ST_RUN |-> !test_mode_out && !normal_mode_out)
        else $error("mode output active outside run");

    a_back_to_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R3]
        !power_on_reset_n_in |=> state == RRTS_ST_RESET)
        else $error("reset input did not return to idle");

    a_normal_all_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R6]
        normal_mode_out |-> test_mode_sel_out == '0)
        else $error("normal mode with a strap high");
endmodule

// ===== tb/rrts_pmic_model.sv
`timescale 1ns/1ps
module rrts_pmic_model #(
    parameter int SETTLE = 4
) (
    input wire logic ref_clk_in, // Clock
    input wire logic go_in, // Supplies switched on
    input wire logic [7:0] pull_up_in, // Board pullups on straps
    input wire logic [7:0] pin_drv_in, // Device pin data
    input wire logic [7:0] pin_oe_n_in, // Device drives when low
    input wire logic [7:0] pin_pd_in, // Device weak pulldown
    output logic por_n_out, // Power-on reset, active low
    output logic [7:0] pin_out // Resolved pin level
);
    int cnt = 0;
    initial por_n_out = 1'b0;
    // Reset stays low until the supplies have had time to settle
    always @(posedge ref_clk_in) begin
        cnt <= go_in ? cnt + 1 : 0;
        por_n_out <= go_in && cnt >= SETTLE;
    end
    // Board pullup beats the weak pulldown; a floating pin with no pullup and the pulldown off shows the inverse of its data
    assign pin_out = (~pin_oe_n_in & pin_drv_in) |
        (pin_oe_n_in & (pull_up_in | (~pin_pd_in & ~pin_drv_in)));
endmodule

// ===== tb/rrts_top_tb_top.sv
`timescale 1ns/1ps
module rrts_top_tb_top;
    import rrts_pkg::*;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, go = 1'b0;
    logic [7:0] pull_up = 8'h00, test_data = 8'h00, pins, drv, oe_n, pd, sel;
    logic por_n, tmode, nmode, cstart, cact;
    int n_mismatch = 0, check_count = 0;
    initial forever #5 ref_clk_in = ~ref_clk_in;
    rrts_pmic_model i_rrts_pmic_model (.ref_clk_in(ref_clk_in), .go_in(go),
        .pull_up_in(pull_up), .pin_drv_in(drv), .pin_oe_n_in(oe_n), .pin_pd_in(pd),
        .por_n_out(por_n), .pin_out(pins));
    rrts_top i_rrts_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .power_on_reset_n_in(por_n), .test_strap_pin_in(pins), .test_strap_pin_out(drv),
        .test_strap_pin_oe_n_out(oe_n), .test_strap_pin_pd_out(pd), .test_data_in(test_data),
        .test_mode_sel_out(sel), .test_mode_out(tmode), .normal_mode_out(nmode),
        .config_start_out(cstart), .config_active_out(cact));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_held;
        go = 1'b0;
        pull_up = 8'hff;
        tick(3);
        check({cstart, cact, tmode, nmode}, 4'h0);
        check(sel, 8'h00);
        check(oe_n, 8'hff);
        check(pd, 8'hff);
        $display("test held done");
    endtask
    task automatic test_run(input logic [7:0] p);
        int n;
        pull_up = p;
        go = 1'b1;
        n = 0;
        while (por_n !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (n >= 50) begin
            n_mismatch++;
            wrap_up();
        end
        n = 0;
        // Edge after the first high sample is where the rise is taken
        while (cstart !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check(n[15:0], 16'(STRAP_DELAY_CYC + 2));
        if (n >= 400) wrap_up();
        check({cact, sel}, {1'b1, p});
        check(oe_n, 8'h00);
        tick(1);
        check(cstart, 1'b0);
        check({tmode, nmode}, {p != 8'h00, p == 8'h00});
        test_data = 8'h5a;
        pull_up = ~p;
        tick(4);
        check(pins, 8'h5a);
        check({tmode, nmode, sel}, {p != 8'h00, p == 8'h00, p});
        $display("test run %h done", p);
        test_held();
    endtask
    initial begin
        tick(20);
        rst_n_in = 1'b1;
        test_held();
        test_run(8'h00);
        test_run(8'h81);
        test_run(8'h40);
        wrap_up();
    end
endmodule
